/* File: logic/macd_pkg.sv */
// shared types and constants for the memory area command decoder
package macd_pkg;
  typedef struct packed {
    logic [7:0] info_control_byte;
    logic [7:0] reserved_header_byte;
    logic [7:0] gateway_count;
    logic [7:0] dest_network;
    logic [7:0] dest_node;
    logic [7:0] dest_unit;
    logic [7:0] src_network;
    logic [7:0] src_node;
    logic [7:0] src_unit;
    logic [7:0] service_tag;
  } macd_hdr_t;

  typedef enum logic [2:0] {
    AREA_GIO = 3'b000,
    AREA_LINK = 3'b001,
    AREA_HOLD = 3'b010,
    AREA_AUX = 3'b011,
    AREA_TC_FLAG = 3'b100,
    AREA_TC_PV = 3'b101,
    AREA_DM = 3'b110,
    AREA_EM = 3'b111
  } macd_area_t;

  typedef struct packed {
    macd_area_t area;
    logic [15:0] comm_addr;
    logic [15:0] word_off;
    logic [3:0] bit_num;
    logic is_bit;
    logic [1:0] elem_bytes;
    logic [3:0] bank;
    logic [15:0] count;
    logic is_write;
  } macd_acc_t;

  // frame byte positions
  localparam int IDX_RSV = 1;
  localparam int IDX_GATEWAY_COUNT = 2;
  localparam int IDX_MRC = 10;
  localparam int IDX_SRC = 11;
  localparam int IDX_AREA = 12;
  localparam int IDX_ADDR_HI = 13;
  localparam int IDX_ADDR_LO = 14;
  localparam int IDX_BITNUM = 15;
  localparam int IDX_CNT_HI = 16;
  localparam int IDX_CNT_LO = 17;
  localparam int IDX_DATA0 = 18;
  localparam int IDX_DATA1 = 19;
  localparam int FRAME_BYTES = 20;
  localparam logic [4:0] LEN_HDR = 5'h0a;
  localparam logic [4:0] LEN_CMD = 5'h12;
  localparam logic [4:0] LEN_WR_BIT = 5'h13;
  localparam logic [4:0] LEN_WR_WORD = 5'h14;
  localparam logic [4:0] LEN_MAX = 5'h1f;

  localparam logic [7:0] RSV_VALUE = 8'h00;
  localparam logic [7:0] GATEWAY_COUNT_VALUE = 8'h02;
  localparam logic [7:0] NET_MIN = 8'h01;
  localparam logic [7:0] NET_MAX = 8'h7f;
  localparam logic [7:0] UNIT_CPU = 8'h00;
  localparam logic [7:0] UNIT_SIO_MIN = 8'h10;
  localparam logic [7:0] UNIT_SIO_MAX = 8'h1f;
  localparam logic [7:0] UNIT_COMM = 8'hfe;

  localparam logic [7:0] CMD_MEM = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;

  localparam logic [7:0] CODE_BIT = 8'h00;
  localparam logic [7:0] CODE_WORD = 8'h80;
  localparam logic [7:0] CODE_TC_FLAG = 8'h01;
  localparam logic [7:0] CODE_TC_PV = 8'h81;
  localparam logic [7:0] CODE_DM = 8'h82;
  localparam logic [7:0] CODE_EM_LO = 8'h90;
  localparam logic [7:0] CODE_EM_HI = 8'h97;
  localparam logic [7:0] CODE_EM_CUR = 8'h98;
  localparam logic [7:0] CODE_EMX_LO = 8'ha8;
  localparam logic [7:0] CODE_EMX_HI = 8'haf;
  localparam logic [3:0] EMX_FIRST_BANK = 4'h8;

  localparam logic [15:0] GIO_LAST = 16'h01ff;
  localparam logic [15:0] LINK_BASE = 16'h03e8;
  localparam logic [15:0] HOLD_BASE = 16'h0428;
  localparam logic [15:0] AUX_BASE = 16'h048c;
  localparam logic [15:0] AUX_LAST = 16'h04a7;
  localparam logic [15:0] TC_LAST = 16'h01ff;
  localparam logic [15:0] DM_LAST = 16'h270f;
  localparam logic [15:0] EM_LAST = 16'h17ff;
  localparam logic [7:0] BIT_MAX = 8'h0f;
  localparam logic [7:0] BIT_NONE = 8'h00;

  localparam logic [7:0] ELEM_OFF = 8'h00;
  localparam logic [7:0] ELEM_ON = 8'h01;
  localparam logic [1:0] BYTES_BIT = 2'h1;
  localparam logic [1:0] BYTES_WORD = 2'h2;

  localparam logic [7:0] MAIN_NORMAL = 8'h00;
  localparam logic [7:0] MAIN_NOT_EXEC = 8'h04;
  localparam logic [7:0] MAIN_ROUTING = 8'h05;
  localparam logic [7:0] MAIN_FORMAT = 8'h10;
  localparam logic [7:0] MAIN_PARAM = 8'h11;
  localparam logic [7:0] SUB_NONE = 8'h00;
  localparam logic [7:0] SUB_TABLE = 8'h01;
  localparam logic [7:0] SUB_DEST = 8'h02;
  localparam logic [7:0] SUB_SRC = 8'h03;
  localparam logic [7:0] SUB_HEADER = 8'h01;
  localparam logic [7:0] SUB_SHORT = 8'h02;
  localparam logic [7:0] SUB_AREA = 8'h01;
  localparam logic [7:0] SUB_ADDR = 8'h02;
  localparam logic [7:0] SUB_BIT = 8'h03;
  localparam logic [7:0] SUB_COUNT = 8'h04;
endpackage

/* File: logic/macd_elem_codec.sv */
// bit and word data element encode and decode
`timescale 1ns/1ps
module macd_elem_codec (
  input wire logic i_is_bit,
  input wire logic [7:0] i_wr_hi,
  input wire logic [7:0] i_wr_lo,
  input wire logic [15:0] i_rd_value,
  output logic [15:0] o_wr_value,
  output logic [15:0] o_rd_bytes,
  output logic [1:0] o_elem_bytes
);
  always_comb begin
    if (i_is_bit) begin
      // only 01 counts as on; other values read as off
      o_wr_value = {15'h0000, i_wr_hi == macd_pkg::ELEM_ON};
      o_rd_bytes = {(i_rd_value[0] ? macd_pkg::ELEM_ON
                                   : macd_pkg::ELEM_OFF),
                    8'h00};
      o_elem_bytes = macd_pkg::BYTES_BIT;
    end else begin
      o_wr_value = {i_wr_hi, i_wr_lo};
      o_rd_bytes = i_rd_value;
      o_elem_bytes = macd_pkg::BYTES_WORD;
    end
  end
endmodule

/* File: logic/macd_decoder.sv */
// memory area command frame decoder and response former
//
// Behaviour
// - area code 00 is bit access, 1 byte; 80 is word access, 2 bytes
// - link at 03E8, holding at 0428, auxiliary 048C-04A7, general 0000-01FF
// - timer/counter flags code 01 bytes, values code 81 words, 0000-01FF
// - expansion code 98 active bank, 90-97 banks 0-7, A8-AF banks 8-15
// - address is word then bit byte; bit 00-0F for area code 00, 00 for every other code
// - area offset plus area base gives the communication word address
// - bit element one byte 00 off 01 on; words are two bytes
// - response swaps source and destination, keeps tag, adds result code
// - destination network lies in 01 to 7F
// - destination node 00 is local, 1 to 127 an ethernet node
// - destination unit 00 CPU, 10-1F special units, FE comms unit
// - source fields follow the same ranges as destination fields
// - unconfigured node address table gives an error response
// - first result byte main code, 00 normal; second byte detail
`timescale 1ns/1ps
module macd_decoder #(
  parameter int ICF_RESP_BIT = 6,
  parameter int ICF_NOREPLY_BIT = 0
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  output logic o_rx_ready,
  input wire logic i_table_ok,
  input wire logic [3:0] i_current_bank,
  input wire logic [15:0] i_rd_value,
  output logic o_resp_valid,
  output macd_pkg::macd_hdr_t o_resp_hdr,
  output logic [7:0] o_main_result,
  output logic [7:0] o_sub_result,
  output logic o_acc_valid,
  output macd_pkg::macd_acc_t o_acc,
  output logic [15:0] o_wr_value,
  output logic [15:0] o_rd_bytes
);
  typedef enum logic {
    ST_RECV = 1'b0,
    ST_EVAL = 1'b1
  } macd_state_t;

  logic rst_meta_reg;
  logic rst_n_sync;
  macd_state_t state_reg;
  logic [4:0] len_reg;
  logic [7:0] frame_reg [0:macd_pkg::FRAME_BYTES-1];
  macd_pkg::macd_hdr_t hdr_c;
  macd_pkg::macd_acc_t acc_c;
  logic [7:0] main_c;
  logic [7:0] sub_c;
  logic drop_c;
  logic [15:0] wr_value_c;
  logic [1:0] elem_bytes_c;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n_sync);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync <= rst_meta_reg;
    end
  end

  assign o_rx_ready = (state_reg == ST_RECV);

  always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= ST_RECV;
    end else begin
      case (state_reg)
        ST_RECV: begin
          if (i_rx_valid && i_rx_last) begin
            state_reg <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          state_reg <= ST_RECV;
        end
        default: begin
          state_reg <= ST_RECV;
        end
      endcase
    end
  end

  // length saturates; bytes past the buffer are counted but not kept
  always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      len_reg <= 5'h00;
      for (int i = 0; i < macd_pkg::FRAME_BYTES; i++) begin
        frame_reg[i] <= 8'h00;
      end
    end else if (state_reg == ST_EVAL) begin
      len_reg <= 5'h00;
    end else if (i_rx_valid) begin
      if (int'(len_reg) < macd_pkg::FRAME_BYTES) begin
        frame_reg[len_reg] <= i_rx_data;
      end
      if (len_reg != macd_pkg::LEN_MAX) begin
        len_reg <= len_reg + 5'h01;
      end
    end
  end

  assign hdr_c = {frame_reg[0], frame_reg[1], frame_reg[2], frame_reg[3],
                  frame_reg[4], frame_reg[5], frame_reg[6], frame_reg[7],
                  frame_reg[8], frame_reg[9]};

  function automatic logic net_ok(input logic [7:0] b);
    net_ok = (b >= macd_pkg::NET_MIN) && (b <= macd_pkg::NET_MAX);
  endfunction

  function automatic logic unit_ok(input logic [7:0] b);
    unit_ok = (b == macd_pkg::UNIT_CPU) || (b == macd_pkg::UNIT_COMM) ||
              ((b >= macd_pkg::UNIT_SIO_MIN) &&
               (b <= macd_pkg::UNIT_SIO_MAX));
  endfunction

  // area decode: code picks area and width, address picks the range
  logic [7:0] code_c;
  logic [15:0] addr_c;
  logic [15:0] base_c;
  logic [7:0] bit_lim_c;
  logic area_bad_c;
  logic addr_bad_c;
  always_comb begin
    code_c = frame_reg[macd_pkg::IDX_AREA];
    addr_c = {frame_reg[macd_pkg::IDX_ADDR_HI],
              frame_reg[macd_pkg::IDX_ADDR_LO]};
    acc_c = '0;
    base_c = 16'h0000;
    bit_lim_c = macd_pkg::BIT_NONE;
    area_bad_c = 1'b0;
    addr_bad_c = 1'b0;
    if (code_c == macd_pkg::CODE_BIT || code_c == macd_pkg::CODE_WORD) begin
      acc_c.is_bit = (code_c == macd_pkg::CODE_BIT);
      if (acc_c.is_bit) begin
        bit_lim_c = macd_pkg::BIT_MAX;
      end
      if (addr_c <= macd_pkg::GIO_LAST) begin
        acc_c.area = macd_pkg::AREA_GIO;
      end else if (addr_c >= macd_pkg::LINK_BASE &&
                   addr_c < macd_pkg::HOLD_BASE) begin
        acc_c.area = macd_pkg::AREA_LINK;
        base_c = macd_pkg::LINK_BASE;
      end else if (addr_c >= macd_pkg::HOLD_BASE &&
                   addr_c < macd_pkg::AUX_BASE) begin
        acc_c.area = macd_pkg::AREA_HOLD;
        base_c = macd_pkg::HOLD_BASE;
      end else if (addr_c >= macd_pkg::AUX_BASE &&
                   addr_c <= macd_pkg::AUX_LAST) begin
        acc_c.area = macd_pkg::AREA_AUX;
        base_c = macd_pkg::AUX_BASE;
      end else begin
        addr_bad_c = 1'b1;
      end
    end else if (code_c == macd_pkg::CODE_TC_FLAG ||
                 code_c == macd_pkg::CODE_TC_PV) begin
      acc_c.is_bit = (code_c == macd_pkg::CODE_TC_FLAG);
      acc_c.area = acc_c.is_bit ? macd_pkg::AREA_TC_FLAG
                                : macd_pkg::AREA_TC_PV;
      addr_bad_c = (addr_c > macd_pkg::TC_LAST);
    end else if (code_c == macd_pkg::CODE_DM) begin
      acc_c.area = macd_pkg::AREA_DM;
      addr_bad_c = (addr_c > macd_pkg::DM_LAST);
    end else if (code_c == macd_pkg::CODE_EM_CUR) begin
      acc_c.area = macd_pkg::AREA_EM;
      acc_c.bank = i_current_bank;
      addr_bad_c = (addr_c > macd_pkg::EM_LAST);
    end else if (code_c >= macd_pkg::CODE_EM_LO &&
                 code_c <= macd_pkg::CODE_EM_HI) begin
      acc_c.area = macd_pkg::AREA_EM;
      acc_c.bank = 4'(code_c - macd_pkg::CODE_EM_LO);
      addr_bad_c = (addr_c > macd_pkg::EM_LAST);
    end else if (code_c >= macd_pkg::CODE_EMX_LO &&
                 code_c <= macd_pkg::CODE_EMX_HI) begin
      acc_c.area = macd_pkg::AREA_EM;
      acc_c.bank = 4'(code_c - macd_pkg::CODE_EMX_LO) +
                   macd_pkg::EMX_FIRST_BANK;
      addr_bad_c = (addr_c > macd_pkg::EM_LAST);
    end else begin
      area_bad_c = 1'b1;
    end
    acc_c.comm_addr = addr_c;
    acc_c.word_off = addr_c - base_c;
    acc_c.bit_num = frame_reg[macd_pkg::IDX_BITNUM][3:0];
    acc_c.elem_bytes = elem_bytes_c;
    acc_c.count = {frame_reg[macd_pkg::IDX_CNT_HI],
                   frame_reg[macd_pkg::IDX_CNT_LO]};
    acc_c.is_write = (frame_reg[macd_pkg::IDX_SRC] == macd_pkg::CMD_WRITE);
  end

  macd_elem_codec u_codec (
    .i_is_bit(acc_c.is_bit),
    .i_wr_hi(frame_reg[macd_pkg::IDX_DATA0]),
    .i_wr_lo(frame_reg[macd_pkg::IDX_DATA1]),
    .i_rd_value(i_rd_value),
    .o_wr_value(wr_value_c),
    .o_rd_bytes(),
    .o_elem_bytes(elem_bytes_c)
  );

  // checks in priority order; the first failure names the result
  always_comb begin
    main_c = macd_pkg::MAIN_NORMAL;
    sub_c = macd_pkg::SUB_NONE;
    // too short to echo, or itself a response: nothing to answer
    drop_c = (len_reg < macd_pkg::LEN_HDR) ||
             hdr_c.info_control_byte[ICF_RESP_BIT];
    if (!i_table_ok) begin
      main_c = macd_pkg::MAIN_ROUTING;
      sub_c = macd_pkg::SUB_TABLE;
    end else if (hdr_c.reserved_header_byte != macd_pkg::RSV_VALUE ||
                 hdr_c.gateway_count != macd_pkg::GATEWAY_COUNT_VALUE) begin
      main_c = macd_pkg::MAIN_FORMAT;
      sub_c = macd_pkg::SUB_HEADER;
    end else if (!net_ok(hdr_c.dest_network) ||
                 hdr_c.dest_node > macd_pkg::NET_MAX ||
                 !unit_ok(hdr_c.dest_unit)) begin
      main_c = macd_pkg::MAIN_ROUTING;
      sub_c = macd_pkg::SUB_DEST;
    end else if (!net_ok(hdr_c.src_network) ||
                 hdr_c.src_node > macd_pkg::NET_MAX ||
                 !unit_ok(hdr_c.src_unit)) begin
      main_c = macd_pkg::MAIN_ROUTING;
      sub_c = macd_pkg::SUB_SRC;
    end else if (len_reg < macd_pkg::LEN_CMD) begin
      main_c = macd_pkg::MAIN_FORMAT;
      sub_c = macd_pkg::SUB_SHORT;
    end else if (frame_reg[macd_pkg::IDX_MRC] != macd_pkg::CMD_MEM ||
                 (frame_reg[macd_pkg::IDX_SRC] != macd_pkg::CMD_READ &&
                  frame_reg[macd_pkg::IDX_SRC] != macd_pkg::CMD_WRITE)) begin
      main_c = macd_pkg::MAIN_NOT_EXEC;
    end else if (area_bad_c) begin
      main_c = macd_pkg::MAIN_PARAM;
      sub_c = macd_pkg::SUB_AREA;
    end else if (addr_bad_c) begin
      main_c = macd_pkg::MAIN_PARAM;
      sub_c = macd_pkg::SUB_ADDR;
    end else if (frame_reg[macd_pkg::IDX_BITNUM] > bit_lim_c) begin
      main_c = macd_pkg::MAIN_PARAM;
      sub_c = macd_pkg::SUB_BIT;
    end else if (acc_c.count == 16'h0000) begin
      main_c = macd_pkg::MAIN_PARAM;
      sub_c = macd_pkg::SUB_COUNT;
    end else if (acc_c.is_write &&
                 len_reg < (acc_c.is_bit ? macd_pkg::LEN_WR_BIT
                                         : macd_pkg::LEN_WR_WORD)) begin
      main_c = macd_pkg::MAIN_FORMAT;
      sub_c = macd_pkg::SUB_SHORT;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_resp_valid <= 1'b0;
      o_acc_valid <= 1'b0;
    end else begin
      o_resp_valid <= (state_reg == ST_EVAL) && !drop_c &&
                      !hdr_c.info_control_byte[ICF_NOREPLY_BIT];
      o_acc_valid <= (state_reg == ST_EVAL) && !drop_c &&
                     (main_c == macd_pkg::MAIN_NORMAL);
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_resp_hdr <= '0;
      o_main_result <= 8'h00;
      o_sub_result <= 8'h00;
      o_acc <= '0;
      o_wr_value <= 16'h0000;
    end else if (state_reg == ST_EVAL) begin
      o_resp_hdr <= hdr_c;
      o_resp_hdr.info_control_byte[ICF_RESP_BIT] <= 1'b1;
      o_resp_hdr.dest_network <= hdr_c.src_network;
      o_resp_hdr.dest_node <= hdr_c.src_node;
      o_resp_hdr.dest_unit <= hdr_c.src_unit;
      o_resp_hdr.src_network <= hdr_c.dest_network;
      o_resp_hdr.src_node <= hdr_c.dest_node;
      o_resp_hdr.src_unit <= hdr_c.dest_unit;
      o_main_result <= main_c;
      o_sub_result <= sub_c;
      o_acc <= acc_c;
      o_wr_value <= wr_value_c;
    end
  end

  // read data follows the last decoded access width
  always_ff @(posedge i_sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_rd_bytes <= 16'h0000;
    end else begin
      o_rd_bytes <= o_acc.is_bit ? {(i_rd_value[0] ? macd_pkg::ELEM_ON
                                                   : macd_pkg::ELEM_OFF),
                                    8'h00}
                                 : i_rd_value;
    end
  end

  a_resp_swap: assert property (o_resp_valid |->
    o_resp_hdr.dest_network == frame_reg[6] &&
    o_resp_hdr.src_node == frame_reg[4] &&
    o_resp_hdr.service_tag == frame_reg[9])
    else $error("response header not swapped");
  a_table_error: assert property (
    (state_reg == ST_EVAL && !i_table_ok) |=>
    o_main_result == macd_pkg::MAIN_ROUTING && !o_acc_valid)
    else $error("missing table error");
  a_acc_normal: assert property (o_acc_valid |->
    o_main_result == macd_pkg::MAIN_NORMAL)
    else $error("access issued with error result");
  a_bit_number: assert property (o_acc_valid |->
    (o_acc.is_bit && o_acc.area != macd_pkg::AREA_TC_FLAG) ||
    o_acc.bit_num == 4'h0)
    else $error("bit number on word access");
  a_link_range: assert property (
    o_acc_valid && o_acc.area == macd_pkg::AREA_LINK |->
    o_acc.word_off + macd_pkg::LINK_BASE == o_acc.comm_addr &&
    o_acc.comm_addr < macd_pkg::HOLD_BASE)
    else $error("link offset wrong");
  a_em_range: assert property (
    o_acc_valid && o_acc.area == macd_pkg::AREA_EM |->
    o_acc.word_off <= macd_pkg::EM_LAST && !o_acc.is_bit)
    else $error("expansion access out of range");
  a_tc_range: assert property (
    o_acc_valid && o_acc.area == macd_pkg::AREA_TC_PV |->
    o_acc.comm_addr <= macd_pkg::TC_LAST && !o_acc.is_bit)
    else $error("timer value access wrong");
  a_elem_width: assert property (o_acc_valid |->
    o_acc.elem_bytes ==
    (o_acc.is_bit ? macd_pkg::BYTES_BIT : macd_pkg::BYTES_WORD))
    else $error("element width mismatch");
  a_resp_once: assert property (o_resp_valid |=>
    !o_resp_valid ##1 !o_resp_valid)
    else $error("response repeated");
endmodule

/* File: test/macd_host_model.sv */
// host side model that sends command frames byte by byte
`timescale 1ns/1ps
module macd_host_model (
  input wire logic i_sys_clk,
  input wire logic i_rx_ready,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_last
);
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_last = 1'b0;
  end
  // ready is state only, so its value at the falling edge holds at the rise
  task automatic send(input logic [7:0] f [20], input int len);
    logic rdy;
    for (int i = 0; i < len; i++) begin
      @(negedge i_sys_clk);
      o_valid = 1'b1;
      o_data = f[i];
      o_last = (i == len - 1);
      rdy = i_rx_ready;
      @(posedge i_sys_clk);
      while (rdy !== 1'b1) begin
        @(negedge i_sys_clk);
        rdy = i_rx_ready;
        @(posedge i_sys_clk);
      end
    end
    @(negedge i_sys_clk);
    o_valid = 1'b0;
    o_last = 1'b0;
    // released line must not keep showing the last byte
    o_data = ~o_data;
  endtask
endmodule

/* File: test/macd_decoder_bench.sv */
// self-checking bench for the memory area command decoder
`timescale 1ns/1ps
module macd_decoder_bench;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_table_ok = 1'b1;
  logic [3:0] i_current_bank = 4'h0;
  logic [15:0] i_rd_value = 16'h0000;
  logic i_rx_valid, i_rx_last, o_rx_ready, o_resp_valid, o_acc_valid;
  logic [7:0] i_rx_data, o_main_result, o_sub_result;
  logic [15:0] o_wr_value, o_rd_bytes;
  macd_pkg::macd_hdr_t o_resp_hdr;
  macd_pkg::macd_acc_t o_acc;
  int fail_count = 0;
  int num_checks = 0;
  logic [7:0] frm [20];
  logic [7:0] codes [12] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h82, 8'h90,
    8'h97, 8'h98, 8'ha8, 8'haf, 8'h55, 8'h83};
  logic [15:0] adrs [16] = '{16'h0000, 16'h01ff, 16'h0200, 16'h03e7,
    16'h03e8, 16'h0427, 16'h0428, 16'h048b, 16'h048c, 16'h04a7, 16'h04a8,
    16'h17ff, 16'h1800, 16'h270f, 16'h2710, 16'h0499};

  always #50 i_sys_clk = ~i_sys_clk;

  macd_decoder DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_last(i_rx_last),
    .o_rx_ready(o_rx_ready), .i_table_ok(i_table_ok),
    .i_current_bank(i_current_bank), .i_rd_value(i_rd_value),
    .o_resp_valid(o_resp_valid), .o_resp_hdr(o_resp_hdr),
    .o_main_result(o_main_result), .o_sub_result(o_sub_result),
    .o_acc_valid(o_acc_valid), .o_acc(o_acc), .o_wr_value(o_wr_value),
    .o_rd_bytes(o_rd_bytes));

  macd_host_model host (.i_sys_clk(i_sys_clk), .i_rx_ready(o_rx_ready),
    .o_valid(i_rx_valid), .o_data(i_rx_data), .o_last(i_rx_last));

  task automatic check(input string nm, input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // returns result, area, bank and word offset of a memory reference
  function automatic logic [38:0] mem_exp(input logic [7:0] c,
      input logic [15:0] a, input logic [7:0] b);
    logic [2:0] ar;
    logic [15:0] base;
    logic [15:0] lim;
    logic [3:0] bk;
    {ar, base, lim, bk} = {3'h0, 16'h0000, 16'h01ff, 4'h0};
    if (c == 8'h00 || c == 8'h80) begin
      if (a >= 16'h048c) {ar, base, lim} = {3'h3, 16'h048c, 16'h04a7};
      else if (a >= 16'h0428) {ar, base, lim} = {3'h2, 16'h0428, 16'h048b};
      else if (a >= 16'h03e8) {ar, base, lim} = {3'h1, 16'h03e8, 16'h0427};
    end else if (c == 8'h01 || c == 8'h81) ar = c[7] ? 3'h5 : 3'h4;
    else if (c == 8'h82) {ar, lim} = {3'h6, 16'h270f};
    else if ((c >= 8'h90 && c <= 8'h98) || (c >= 8'ha8 && c <= 8'haf))
      {ar, lim, bk} = {3'h7, 16'h17ff, c == 8'h98 ? i_current_bank : c[3:0]};
    else return {16'h1101, 23'h0};
    if (a < base || a > lim) return {16'h1102, 23'h0};
    if (c == 8'h00 ? b > 8'h0f : b != 8'h00) return {16'h1103, 23'h0};
    return {16'h0000, ar, bk, a - base};
  endfunction

  task automatic run(input int m, input logic [7:0] c, input logic [15:0] a,
      input logic [7:0] b, input logic w);
    logic [7:0] tag;
    logic [7:0] cnt;
    logic [15:0] d;
    logic [38:0] e;
    logic rsp;
    logic acc;
    int len;
    logic [15:0] wx;
    logic [15:0] rx;
    logic [55:0] hs;
    logic [55:0] hx;
    logic [62:0] ag;
    logic [62:0] ae;
    @(negedge i_sys_clk);
    tag = 8'($urandom);
    cnt = 8'($urandom_range(1, 9));
    d = c[7] ? 16'($urandom) : {7'h0, 1'($urandom), 8'h00};
    i_rd_value = c[7] ? 16'($urandom) : {16{1'($urandom)}};
    wx = c[7] ? d : {8'h00, d[15:8]};
    rx = c[7] ? i_rd_value : {7'h0, i_rd_value[0], 8'h00};
    i_current_bank = 4'($urandom);
    i_table_ok = (m != 1);
    frm = '{8'h80, 8'h00, 8'h02, 8'h01, 8'h00, 8'h10, 8'h01, 8'h20, 8'h00,
      tag, 8'h01, w ? 8'h02 : 8'h01, c, a[15:8], a[7:0], b, 8'h00, cnt,
      d[15:8], d[7:0]};
    len = w ? (c[7] ? 20 : 19) : 18;
    e = mem_exp(c, a, b);
    case (m)
      1: e[38:23] = 16'h0501;
      2: frm[1] = 8'h01;
      3: frm[2] = 8'h03;
      4: frm[3] = 8'h00;
      5: frm[5] = 8'h05;
      6: frm[6] = 8'h80;
      7: len = 15;
      8: frm[11] = 8'h04;
      9: frm[17] = 8'h00;
      10: frm[0] = 8'hc0;
      11: frm[0] = 8'h81;
      12: len = 8;
      default: ;
    endcase
    if (m == 2 || m == 3) e[38:23] = 16'h1001;
    if (m == 4 || m == 5) e[38:23] = 16'h0502;
    if (m == 6) e[38:23] = 16'h0503;
    if (m == 7) e[38:23] = 16'h1002;
    if (m == 8) e[38:23] = 16'h0400;
    if (m == 9 && e[38:23] == 16'h0) e[38:23] = 16'h1104;
    rsp = (m < 10);
    acc = (m != 10 && m != 12 && e[38:23] == 16'h0);
    hx = {frm[6], frm[7], frm[8], frm[3], frm[4], frm[5], tag};
    ae = {e[22:20], a, e[15:0], e[19:16], c[7] ? 2'h2 : 2'h1, ~c[7],
      b[3:0], 8'h00, cnt, w};
    host.send(frm, len);
    check("ready", o_rx_ready, 1'b0);
    // pulses stand only in the cycle after the evaluate edge
    @(posedge i_sys_clk);
    #1;
    hs = {o_resp_hdr.dest_network, o_resp_hdr.dest_node,
      o_resp_hdr.dest_unit, o_resp_hdr.src_network, o_resp_hdr.src_node,
      o_resp_hdr.src_unit, o_resp_hdr.service_tag};
    ag = {o_acc.area, o_acc.comm_addr, o_acc.word_off,
      (e[22:20] == 3'h7) ? o_acc.bank : 4'h0, o_acc.elem_bytes,
      o_acc.is_bit, o_acc.bit_num, o_acc.count, o_acc.is_write};
    check("resp_valid", o_resp_valid, rsp);
    check("acc_valid", o_acc_valid, acc);
    if (rsp) begin
      check("result", {o_main_result, o_sub_result}, e[38:23]);
      check("swap", hs, hx);
      check("resp_bit", o_resp_hdr.info_control_byte[6], 1'b1);
    end
    if (acc) begin
      check("acc", ag, ae);
      if (w) check("wr_value", o_wr_value, wx);
    end
    // read bytes follow the registered access one edge later
    @(posedge i_sys_clk);
    #1;
    check("resp_pulse", o_resp_valid, 1'b0);
    check("acc_pulse", o_acc_valid, 1'b0);
    if (acc) check("rd_bytes", o_rd_bytes, rx);
  endtask

  initial begin
    void'($urandom(39917));
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    run(0, 8'h00, 16'h0499, 8'h0c, 1'b0);
    run(0, 8'h00, 16'h0000, 8'h0f, 1'b1);
    run(0, 8'h80, 16'h0499, 8'h01, 1'b0);
    run(0, 8'h98, 16'h17ff, 8'h00, 1'b1);
    $display("corner frames done");
    for (int n = 0; n < 160; n++) begin
      run(n < 52 ? n % 13 : 0, codes[$urandom % 12],
        ($urandom % 2) ? adrs[$urandom % 16] : 16'($urandom % 16'h2800),
        8'($urandom % 18), 1'($urandom));
    end
    $display("random frames done");
    tally_and_finish();
  end

  // frames take at most 23 cycles each
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
endmodule
